/* File: micp_irq_ctrl.sv */
// Interrupt controller top: latches, arbitration, wake-up and Avalon-MM registers
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module micp_irq_ctrl #(
    parameter int N1 = 8,
    parameter int N2 = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic nmi_pin_b,
    input wire logic [N1-1:0] vec1_pins,
    input wire logic [N2-1:0] vec2_pins,
    input wire logic [N2-1:0] vec2_pin_irq_en,
    input wire logic tmr_flag,
    input wire logic tmr_irq_en,
    input wire logic adc_flag,
    input wire logic adc_irq_en,
    input wire logic instr_done,
    input wire logic reti_done,
    input wire logic core_in_wait,
    input wire logic core_in_stop,
    output logic pc_load,
    output logic [11:0] pc_vector,
    output logic [2:0] vec_taken,
    output logic wake_up,
    output logic nmi_mode,
    output logic irq_mode
);
    typedef struct packed
    {
        logic [2:0] opt;
        micp_pkg::micp_mode_e mode;
        logic nmi_over_irq;
        logic nmi_prev;
        logic nmi_lat;
        logic v1_prev;
        logic v1_lat;
        logic v2_lat;
        logic pc_load;
        logic [11:0] vec;
        logic [2:0] num;
        logic wake;
        logic ack;
        logic [31:0] rdata;
    } micp_core_s;

    localparam int NS = N1 + N2 + 1;

    micp_core_s st_r;
    micp_core_s st_nxt;
    logic [NS-1:0] pins_s;
    logic nmi_s;
    logic [N1-1:0] v1_s;
    logic [N2-1:0] v2_s;
    logic v2_evt;
    logic global_irq_enable;
    logic sense;
    logic v1_line;
    logic v1_fall;
    logic nmi_fall;
    logic v1_req;
    logic v3_req;
    logic v4_req;
    logic [4:1] mreq;
    logic take_nmi;
    logic take_mask;
    logic acc;
    logic [4:0] pend;

    // All pins cross into the core clock through two flops
    micp_pin_sync #(
        .W(NS),
        .IDLE({NS{1'b1}})
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_in({nmi_pin_b, vec2_pins, vec1_pins}),
        .sync_out(pins_s)
    );

    assign nmi_s = pins_s[NS-1];
    assign v2_s = pins_s[N1 +: N2];
    assign v1_s = pins_s[N1-1:0];

    // Port B shared node with its quirks
    micp_vec2_detect #(
        .NPIN(N2)
    ) u_vec2 (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_sync(v2_s),
        .pin_irq_en(vec2_pin_irq_en),
        .edge_pol(st_r.opt[micp_pkg::OI_POL]),
        .evt(v2_evt)
    );

    // Source decode
    assign global_irq_enable = st_r.opt[micp_pkg::OI_GLOBAL_EN];
    assign sense = st_r.opt[micp_pkg::OI_SENSE];
    assign v1_line = &v1_s;
    assign v1_fall = st_r.v1_prev & ~v1_line;
    assign nmi_fall = st_r.nmi_prev & ~nmi_s;
    assign v1_req = sense ? ~v1_line : st_r.v1_lat;
    assign v3_req = tmr_flag & tmr_irq_en;
    assign v4_req = adc_flag & adc_irq_en;
    assign mreq = {v4_req, v3_req, st_r.v2_lat, v1_req};
    assign pend = {mreq, st_r.nmi_lat};

    // Decisions only at an instruction boundary, not while a return retires
    assign take_nmi = instr_done & ~reti_done & st_r.nmi_lat & (st_r.mode != micp_pkg::MODE_NMI);
    assign take_mask = instr_done & ~reti_done & ~take_nmi & global_irq_enable & (|mreq)
        & (st_r.mode == micp_pkg::MODE_NORM);
    assign acc = avs_read | avs_write;

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.nmi_prev = nmi_s;
        st_nxt.v1_prev = v1_line;
        st_nxt.pc_load = 1'b0;

        // Latches: a new event wins over the clear at routine start
        st_nxt.nmi_lat = (st_r.nmi_lat & ~take_nmi) | nmi_fall;
        st_nxt.v1_lat = sense ? 1'b0 : ((st_r.v1_lat & ~(take_mask & v1_req)) | v1_fall);
        st_nxt.v2_lat = (st_r.v2_lat & ~(take_mask & ~v1_req & st_r.v2_lat)) | v2_evt;

        // Vector selection, fixed priority
        if (take_nmi)
        begin
            st_nxt.pc_load = 1'b1;
            st_nxt.vec = micp_pkg::VEC0_ADDR;
            st_nxt.num = micp_pkg::VNUM_0;
            st_nxt.nmi_over_irq = (st_r.mode == micp_pkg::MODE_IRQ);
            st_nxt.mode = micp_pkg::MODE_NMI;
        end
        else if (take_mask)
        begin
            st_nxt.pc_load = 1'b1;
            st_nxt.mode = micp_pkg::MODE_IRQ;
            if (v1_req)
            begin
                st_nxt.vec = micp_pkg::VEC1_ADDR;
                st_nxt.num = micp_pkg::VNUM_1;
            end
            else if (st_r.v2_lat)
            begin
                st_nxt.vec = micp_pkg::VEC2_ADDR;
                st_nxt.num = micp_pkg::VNUM_2;
            end
            else if (v3_req)
            begin
                st_nxt.vec = micp_pkg::VEC3_ADDR;
                st_nxt.num = micp_pkg::VNUM_3;
            end
            else
            begin
                st_nxt.vec = micp_pkg::VEC4_ADDR;
                st_nxt.num = micp_pkg::VNUM_4;
            end
        end
        else if (reti_done)
        begin
            // Return from interrupt unwinds one level
            case (st_r.mode)
                micp_pkg::MODE_NMI:
                begin
                    st_nxt.mode = st_r.nmi_over_irq ? micp_pkg::MODE_IRQ : micp_pkg::MODE_NORM;
                    st_nxt.nmi_over_irq = 1'b0;
                end
                micp_pkg::MODE_IRQ:
                begin
                    st_nxt.mode = micp_pkg::MODE_NORM;
                end
                micp_pkg::MODE_NORM:
                begin
                    st_nxt.mode = micp_pkg::MODE_NORM;
                end
                default:
                begin
                    st_nxt.mode = micp_pkg::MODE_NORM;
                end
            endcase
        end

        // Wake: with global enable set, wait ends on any request, stop not on the converter
        st_nxt.wake = global_irq_enable & ((core_in_wait & (st_r.nmi_lat | (|mreq)))
            | (core_in_stop & (st_r.nmi_lat | v1_req | st_r.v2_lat | v3_req)));

        // Bus slave: one wait cycle, then the access completes
        st_nxt.ack = acc & ~st_r.ack;
        if (acc & ~st_r.ack)
        begin
            st_nxt.rdata = '0;
            if (avs_read && avs_address == micp_pkg::OFS_STATUS)
            begin
                st_nxt.rdata[micp_pkg::STS_PEND_LSB +: 5] = pend;
                st_nxt.rdata[micp_pkg::STS_MODE_LSB +: 3] = st_r.mode;
                st_nxt.rdata[micp_pkg::STS_NUM_LSB +: 3] = st_r.num;
                st_nxt.rdata[micp_pkg::STS_OPT_LSB +: 3] = st_r.opt;
            end
        end
        if (avs_write && st_r.ack && avs_byteenable[0] && avs_address == micp_pkg::OFS_OPTION)
        begin
            st_nxt.opt[micp_pkg::OI_SENSE] = avs_writedata[micp_pkg::OPT_SENSE_BIT];
            st_nxt.opt[micp_pkg::OI_POL] = avs_writedata[micp_pkg::OPT_POL_BIT];
            st_nxt.opt[micp_pkg::OI_GLOBAL_EN] = avs_writedata[micp_pkg::OPT_GLOBAL_EN_BIT];
        end
    end

    // State register; reset aborts any routine and enters init in NMI mode
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '{opt: micp_pkg::OPT_RESET, mode: micp_pkg::MODE_NMI, nmi_over_irq: 1'b0,
                nmi_prev: 1'b1, nmi_lat: 1'b0, v1_prev: 1'b1, v1_lat: 1'b0, v2_lat: 1'b0,
                pc_load: 1'b0, vec: '0, num: '0, wake: 1'b0, ack: 1'b0, rdata: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign avs_waitrequest = acc & ~st_r.ack;
    assign avs_readdata = st_r.rdata;
    assign pc_load = st_r.pc_load;
    assign pc_vector = st_r.vec;
    assign vec_taken = st_r.num;
    assign wake_up = st_r.wake;
    assign nmi_mode = (st_r.mode == micp_pkg::MODE_NMI);
    assign irq_mode = (st_r.mode == micp_pkg::MODE_IRQ);

    // Checks on the arbitration, bus timing, nmi latch, level mode and stop wake-up
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_bus_req;
        acc && avs_waitrequest;
    endsequence

    sequence s_bus_done;
        !avs_waitrequest ##1 !st_r.ack;
    endsequence

    a_bus_one_wait:
    assert property (s_bus_req |=> s_bus_done)
        else $error("bus access not answered after one wait cycle");

    a_nmi_vector_addr:
    assert property (pc_load && vec_taken == micp_pkg::VNUM_0 |-> pc_vector == micp_pkg::VEC0_ADDR && nmi_mode)
        else $error("nmi taken with wrong vector or mode");

    a_nmi_no_nest:
    assert property (pc_load && vec_taken == micp_pkg::VNUM_0 |-> $past(st_r.mode) != micp_pkg::MODE_NMI)
        else $error("nmi pre-empted an nmi routine");

    a_mask_needs_enable:
    assert property (pc_load && vec_taken != micp_pkg::VNUM_0 |-> $past(global_irq_enable) && irq_mode)
        else $error("maskable vector taken while disabled");

    a_mask_no_nest:
    assert property (pc_load && vec_taken != micp_pkg::VNUM_0 |-> $past(st_r.mode) == micp_pkg::MODE_NORM)
        else $error("maskable routine nested");

    a_vec1_first:
    assert property (take_mask && v1_req |=> pc_load && vec_taken == micp_pkg::VNUM_1
        && pc_vector == micp_pkg::VEC1_ADDR)
        else $error("vector 1 not given priority");

    a_boundary_only:
    assert property (pc_load |-> $past(instr_done) && !$past(reti_done))
        else $error("vector taken off an instruction boundary");

    a_nmi_edge_latch:
    assert property (nmi_fall |=> st_r.nmi_lat)
        else $error("nmi falling edge not latched");

    a_nmi_lat_clear:
    assert property (take_nmi && !nmi_fall |=> !st_r.nmi_lat ##0 pc_load)
        else $error("nmi latch not cleared at routine start");

    a_level_no_store:
    assert property (sense |=> !st_r.v1_lat)
        else $error("level mode stored a request");

    a_stop_no_adc:
    assert property (core_in_stop && !core_in_wait && mreq == 4'h8 && !st_r.nmi_lat |=> !wake_up)
        else $error("converter woke the core from stop");

    // Wake-up, latch bookkeeping and the lower priority levels
    sequence s_wait_pending;
        core_in_wait && global_irq_enable && (st_r.nmi_lat || mreq != 4'h0);
    endsequence

    sequence s_stop_pin_pending;
        core_in_stop && global_irq_enable && (v1_req || st_r.v2_lat);
    endsequence

    sequence s_v2_served;
        take_mask && !v1_req && st_r.v2_lat && !v2_evt;
    endsequence

    a_wait_wakes:
    assert property (s_wait_pending |=> wake_up)
        else $error("pending request did not end wait");

    a_stop_pin_wakes:
    assert property (s_stop_pin_pending |=> wake_up)
        else $error("external request did not end stop");

    a_wake_needs_enable:
    assert property (!global_irq_enable |=> !wake_up)
        else $error("wake raised with maskable requests disabled");

    a_v1_latch_clear:
    assert property (take_mask && v1_req && !sense && !v1_fall |=> !st_r.v1_lat)
        else $error("vector 1 latch not cleared at routine start");

    a_v2_latch_clear:
    assert property (s_v2_served |=> !st_r.v2_lat)
        else $error("vector 2 latch not cleared at routine start");

    a_v2_latch_set:
    assert property (v2_evt |=> st_r.v2_lat)
        else $error("vector 2 event not latched");

    a_vec2_before_3:
    assert property (take_mask && !v1_req && st_r.v2_lat |=> vec_taken == micp_pkg::VNUM_2
        && pc_vector == micp_pkg::VEC2_ADDR)
        else $error("vector 2 not given priority");

    a_vec3_before_4:
    assert property (take_mask && !v1_req && !st_r.v2_lat && v3_req |=> vec_taken == micp_pkg::VNUM_3
        && pc_vector == micp_pkg::VEC3_ADDR)
        else $error("vector 3 not given priority");

    a_reti_unwind:
    assert property (reti_done && nmi_mode && st_r.nmi_over_irq |=> irq_mode)
        else $error("return did not resume the pre-empted routine");

    a_nmi_take_any:
    assert property (take_nmi |=> pc_load && nmi_mode && vec_taken == micp_pkg::VNUM_0)
        else $error("accepted nmi not loaded");
endmodule : micp_irq_ctrl

/* File: micp_pkg.sv */
// Constants, types and register layout of the interrupt controller
// Function
// - Four maskable sources plus one non-maskable source, each with its own vector.
// - Maskable service needs the global enable; events latched while disabled wait.
// - Accepting a request loads the program counter with that source's vector.
// - Several events share a vector; flags let software identify the source.
// - Reset overrides everything and aborts any routine in progress.
// - Non-maskable request pre-empts maskable routines but never another non-maskable one.
// - Maskable routines never nest; vector 1 highest down to vector 4 lowest.
// - Any request ends wait; stop ends on pins and timer, not the converter. The code wakes only with global enable set, also for the non-maskable request.
// - Falling edge on the non-maskable pin raises a request regardless of enable.
// - Non-maskable request is held in a flip-flop cleared when its routine starts.
// - Peripheral flag requests only with both global and peripheral enable set.
// - Peripherals use vectors 3 and 4; flags stay set until software clears.
// - External vectors taken only with global enable; pins also wake from stop.
// - Vector 1 selects edge or level operation by a sense-select bit.
// - Vector 2 is always edge triggered, polarity chosen by a polarity bit.
// - Edge latch sets on active edge, clears at routine start, holds one request.
// - Level mode stores nothing; low level sampled at instruction end.
// - Switching vector 2 to rising polarity with a high pin latches a request.
// - One vector 2 pin held at active level blocks edges on the others.
// - Reconfiguring a low vector 2 pin latches a spurious request per polarity.
// - Sense-select 0 gives falling edge, 1 gives low level, for vector 1.
// - Polarity bit 0 gives falling edge, 1 gives rising edge, for vector 2.
// - Routine entry blocks maskable requests, keeps non-maskable active, clears the latch.
package micp_pkg;
    // Vector locations in program space
    localparam int VEC_W = 12;
    localparam logic [11:0] VEC0_ADDR = 12'hFFC;
    localparam logic [11:0] VEC1_ADDR = 12'hFF6;
    localparam logic [11:0] VEC2_ADDR = 12'hFF4;
    localparam logic [11:0] VEC3_ADDR = 12'hFF2;
    localparam logic [11:0] VEC4_ADDR = 12'hFF0;
    localparam logic [2:0] VNUM_0 = 3'h0;
    localparam logic [2:0] VNUM_1 = 3'h1;
    localparam logic [2:0] VNUM_2 = 3'h2;
    localparam logic [2:0] VNUM_3 = 3'h3;
    localparam logic [2:0] VNUM_4 = 3'h4;
    // Register byte offsets
    localparam logic [3:0] OFS_OPTION = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    // Option register bit positions on the bus
    localparam int OPT_SENSE_BIT = 6;
    localparam int OPT_POL_BIT = 5;
    localparam int OPT_GLOBAL_EN_BIT = 4;
    // Index of each option bit in the stored 3-bit copy
    localparam int OI_SENSE = 2;
    localparam int OI_POL = 1;
    localparam int OI_GLOBAL_EN = 0;
    localparam logic [2:0] OPT_RESET = 3'h0;
    // Status register field positions
    localparam int STS_PEND_LSB = 0;
    localparam int STS_MODE_LSB = 8;
    localparam int STS_NUM_LSB = 12;
    localparam int STS_OPT_LSB = 16;
    // Core service mode, one-hot
    typedef enum logic [2:0]
    {
        MODE_NORM = 3'b001,
        MODE_IRQ = 3'b010,
        MODE_NMI = 3'b100
    } micp_mode_e;
endpackage : micp_pkg

/* File: micp_pin_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module micp_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } micp_sync_s;

    micp_sync_s st_r;
    micp_sync_s st_nxt;

    // First stage feeds only the second
    always_comb
    begin
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
    end

    // State register, pins idle high through pull-ups
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= {IDLE, IDLE};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.s2;
endmodule : micp_pin_sync

/* File: micp_vec2_detect.sv */
// Shared-vector edge detector for the port B interrupt pins
`timescale 1ns/100ps
module micp_vec2_detect #(
    parameter int NPIN = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [NPIN-1:0] pin_sync,
    input wire logic [NPIN-1:0] pin_irq_en,
    input wire logic edge_pol,
    output logic evt
);
    typedef struct packed
    {
        logic comb_prev;
        logic [NPIN-1:0] en_prev;
        logic evt;
    } micp_v2_s;

    micp_v2_s st_r;
    micp_v2_s st_nxt;
    logic [NPIN-1:0] act_b;
    logic [NPIN-1:0] spur;
    logic comb;

    // Per pin: active level pulls the shared node low, other pins idle high
    genvar i;
    generate
        for (i = 0; i < NPIN; i++)
        begin : g_pin
            assign act_b[i] = pin_irq_en[i] ? (pin_sync[i] ^ edge_pol) : 1'b1;
            // Leaving interrupt mode with a low pin in rising mode
            assign spur[i] = edge_pol & st_r.en_prev[i] & ~pin_irq_en[i] & ~pin_sync[i];
        end
    endgenerate

    // Wired node: one pin held active masks the others
    assign comb = &act_b;

    // Falling node is the active edge; polarity flips and mode entry also fall it
    always_comb
    begin
        st_nxt.comb_prev = comb;
        st_nxt.en_prev = pin_irq_en;
        st_nxt.evt = (st_r.comb_prev & ~comb) | (|spur);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '{comb_prev: 1'b1, en_prev: '0, evt: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign evt = st_r.evt;
endmodule : micp_vec2_detect

/* File: micp_core_model.sv */
// Core sequencer model: instruction boundaries and returns from interrupt
`timescale 1ns/100ps
module micp_core_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic reti_req,
    output logic instr_done,
    output logic reti_done
);
    logic [1:0] cnt_r;
    // Four-cycle instructions; a return retires apart from any boundary
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r <= 2'h0;
            instr_done <= 1'b0;
            reti_done <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            instr_done <= (cnt_r == 2'h3);
            reti_done <= reti_req && (cnt_r == 2'h1) && !reti_done;
        end
    end
endmodule : micp_core_model

/* File: testbench.sv */
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
module testbench;
    logic mclk, rst_b, avs_read, avs_write, nmi_pin_b, tmr_flag, tmr_irq_en, adc_flag, adc_irq_en;
    logic core_in_wait, core_in_stop, reti_req, instr_done, reti_done;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] vec1_pins, vec2_pins, vec2_pin_irq_en;
    logic avs_waitrequest, pc_load, wake_up, nmi_mode, irq_mode;
    logic [11:0] pc_vector;
    logic [2:0] vec_taken;
    int failures = 0;
    int num_checks = 0;
    micp_irq_ctrl #(.N1(8), .N2(8)) i_micp_irq_ctrl (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .nmi_pin_b(nmi_pin_b), .vec1_pins(vec1_pins), .vec2_pins(vec2_pins),
        .vec2_pin_irq_en(vec2_pin_irq_en), .tmr_flag(tmr_flag), .tmr_irq_en(tmr_irq_en),
        .adc_flag(adc_flag), .adc_irq_en(adc_irq_en), .instr_done(instr_done), .reti_done(reti_done),
        .core_in_wait(core_in_wait), .core_in_stop(core_in_stop), .pc_load(pc_load),
        .pc_vector(pc_vector), .vec_taken(vec_taken), .wake_up(wake_up), .nmi_mode(nmi_mode),
        .irq_mode(irq_mode));
    micp_core_model i_micp_core_model (.mclk(mclk), .rst_b(rst_b), .reti_req(reti_req),
        .instr_done(instr_done), .reti_done(reti_done));
    // Clock at 20 MHz
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic report_and_stop;
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
            failures++;
    endtask : bus
    task automatic opt(input logic [2:0] v);
        bus(1'b1, 4'h0, {25'h0, v, 4'h0});
    endtask : opt
    task automatic expect_take(input logic [11:0] vec, input logic [2:0] num);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pc_load !== 1'b1 && n < 80);
        check("pc_load", pc_load, 1'b1);
        check("pc_vector", pc_vector, vec);
        check("vec_taken", vec_taken, num);
    endtask : expect_take
    task automatic expect_none(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) @(posedge mclk) if (pc_load !== 1'b0) seen = 1'b1;
        check("no take", seen, 1'b0);
    endtask : expect_none
    task automatic do_reti;
        int n;
        n = 0;
        @(posedge mclk);
        reti_req <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (reti_done !== 1'b1 && n < 20);
        if (reti_done !== 1'b1)
            failures++;
        reti_req <= 1'b0;
        // Let the mode update settle before anyone looks at it
        @(posedge mclk);
    endtask : do_reti
    task automatic pulse1;
        vec1_pins[0] <= 1'b0;
        repeat (3) @(posedge mclk);
        vec1_pins[0] <= 1'b1;
    endtask : pulse1
    task automatic pulse_nmi;
        nmi_pin_b <= 1'b0;
        repeat (3) @(posedge mclk);
        nmi_pin_b <= 1'b1;
    endtask : pulse_nmi
    task automatic pulse2;
        vec2_pins[0] <= 1'b0;
        repeat (3) @(posedge mclk);
        vec2_pins[0] <= 1'b1;
    endtask : pulse2
    task automatic t_reset_regs;
        check("nmi_mode", nmi_mode, 1'b1);
        bus(1'b0, 4'h4, 32'h0);
        check("status", rd[18:8], 11'h004);
        do_reti;
        opt(3'h1);
        bus(1'b0, 4'h0, 32'h0);
        check("option read", rd, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("irq_mode", irq_mode, 1'b0);
    endtask : t_reset_regs
    task automatic t_priority;
        opt(3'h0);
        tmr_flag <= 1'b1;
        adc_flag <= 1'b1;
        pulse1;
        expect_none(40);
        opt(3'h1);
        expect_take(12'hFF6, 3'h1);
        check("irq_mode", irq_mode, 1'b1);
        expect_none(30);
        do_reti;
        expect_take(12'hFF2, 3'h3);
        tmr_flag <= 1'b0;
        do_reti;
        expect_take(12'hFF0, 3'h4);
        adc_irq_en <= 1'b0;
        do_reti;
        expect_none(30);
        adc_flag <= 1'b0;
        adc_irq_en <= 1'b1;
    endtask : t_priority
    task automatic t_nmi;
        opt(3'h0);
        pulse_nmi;
        expect_take(12'hFFC, 3'h0);
        do_reti;
        opt(3'h1);
        tmr_flag <= 1'b1;
        expect_take(12'hFF2, 3'h3);
        pulse_nmi;
        expect_take(12'hFFC, 3'h0);
        check("nmi_mode", nmi_mode, 1'b1);
        pulse_nmi;
        expect_none(30);
        do_reti;
        expect_take(12'hFFC, 3'h0);
        do_reti;
        check("irq_mode", irq_mode, 1'b1);
        tmr_flag <= 1'b0;
        do_reti;
        expect_none(20);
    endtask : t_nmi
    task automatic t_vec1;
        opt(3'h5);
        vec1_pins[0] <= 1'b0;
        expect_take(12'hFF6, 3'h1);
        vec1_pins[0] <= 1'b1;
        @(posedge mclk);
        pulse1;
        do_reti;
        expect_none(30);
        opt(3'h1);
        tmr_flag <= 1'b1;
        expect_take(12'hFF2, 3'h3);
        tmr_flag <= 1'b0;
        pulse1;
        repeat (4) @(posedge mclk);
        pulse1;
        do_reti;
        expect_take(12'hFF6, 3'h1);
        do_reti;
        expect_none(30);
    endtask : t_vec1
    task automatic t_vec2;
        vec2_pin_irq_en <= 8'h01;
        pulse2;
        expect_take(12'hFF4, 3'h2);
        do_reti;
        vec2_pins[1] <= 1'b0;
        expect_none(20);
        vec2_pin_irq_en <= 8'h03;
        expect_take(12'hFF4, 3'h2);
        do_reti;
        pulse2;
        expect_none(30);
        vec2_pins[1] <= 1'b1;
        expect_none(20);
        opt(3'h3);
        expect_take(12'hFF4, 3'h2);
        do_reti;
        // Drop the high pin that would mask rising edges on pin 0
        vec2_pin_irq_en <= 8'h01;
        expect_none(20);
        pulse2;
        expect_take(12'hFF4, 3'h2);
        do_reti;
        opt(3'h1);
    endtask : t_vec2
    task automatic t_wake_reset;
        tmr_flag <= 1'b1;
        expect_take(12'hFF2, 3'h3);
        tmr_flag <= 1'b0;
        adc_flag <= 1'b1;
        core_in_stop <= 1'b1;
        repeat (4) @(posedge mclk);
        check("wake stop adc", wake_up, 1'b0);
        core_in_stop <= 1'b0;
        core_in_wait <= 1'b1;
        repeat (4) @(posedge mclk);
        check("wake wait", wake_up, 1'b1);
        core_in_wait <= 1'b0;
        core_in_stop <= 1'b1;
        vec1_pins[0] <= 1'b0;
        opt(3'h5);
        repeat (4) @(posedge mclk);
        check("wake stop pin", wake_up, 1'b1);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        check("reset nmi_mode", nmi_mode, 1'b1);
        check("reset vec", {irq_mode, vec_taken}, 4'h0);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        check("reset wake", wake_up, 1'b0);
        check("reset load", pc_load, 1'b0);
    endtask : t_wake_reset
    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        report_and_stop;
    end
    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        {avs_read, avs_write, reti_req, core_in_wait, core_in_stop, tmr_flag, adc_flag} = 7'h00;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        nmi_pin_b = 1'b1;
        vec1_pins = 8'hFF;
        vec2_pins = 8'hFF;
        vec2_pin_irq_en = 8'h00;
        tmr_irq_en = 1'b1;
        adc_irq_en = 1'b1;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset_regs;
        t_priority;
        t_nmi;
        t_vec1;
        t_vec2;
        t_wake_reset;
        report_and_stop;
    end
endmodule : testbench
